/* logic/ckg_consts.svh */
// Address map, fields and counts of the clock generator
`ifndef CKG_CONSTS_SVH
`define CKG_CONSTS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CKG_ADDR_SLOW    32'h0ffffd50
`define CKG_ADDR_USB     32'h0ffffc1c
`define CKG_ADDR_MOSC    32'h0ffffc20
`define CKG_ADDR_PLL     32'h0ffffc28
`define CKG_ADDR_MCK     32'h0ffffc30
`define CKG_ADDR_SR      32'h0ffffc68
`define CKG_ADDR_IMR     32'h0ffffc6c

// ****************************************************************
// Field positions
// ****************************************************************
`define CKG_SLOW_RC      0
`define CKG_SLOW_XTAL    1
`define CKG_SLOW_BYP     2
`define CKG_SLOW_SEL     3
`define CKG_SLOW_W       4
`define CKG_MOSC_ON      0
`define CKG_MOSC_BYP     1
`define CKG_MOSC_CNT     15:8
`define CKG_PLL_DIV      7:0
`define CKG_PLL_CNT      13:8
`define CKG_PLL_MUL      26:16
`define CKG_MCK_HALVE    12
`define CKG_USB_ON       16
`define CKG_USB_CNT      23:20
`define CKG_USB_BIAS     24
`define CKG_SR_MOSC      0
`define CKG_SR_PLL       1
`define CKG_SR_USB       6
`define CKG_SR_W         7

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CKG_SLOW_RST     4'h1
`define CKG_SR_MASK      7'h43
`define CKG_DIV8_LAST    3'h7
`define CKG_USB_MULT     8'h28
`define CKG_PIN_RC       0
`define CKG_PIN_OSC      1
`define CKG_PIN_EXT      2

`endif

/* logic/ckg_pkg.sv */
// Types shared by the clock generator modules
package ckg_pkg;
    typedef logic [31:0] ckg_word_t;
    typedef logic [7:0]  ckg_count_t;
    typedef enum logic [1:0] {
        CKG_RESP_OKAY   = 2'h0,
        CKG_RESP_SLVERR = 2'h2
    } ckg_resp_t;
endpackage

/* logic/ckg_cnt_if.sv */
// Link between the control logic and one settle counter
`timescale 1ns/1ps
interface ckg_cnt_if;
    import ckg_pkg::*;
    logic       load;
    ckg_count_t start_val;
    logic       tick;
    logic       done;
    modport ctl (output load, output start_val, output tick, input done);
    modport cnt (input load, input start_val, input tick, output done);
endinterface

/* logic/ckg_settle_counter.sv */
// Down-counter that times an oscillator or PLL start-up
`timescale 1ns/1ps
`include "ckg_consts.svh"
module ckg_settle_counter
    import ckg_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control link
    ckg_cnt_if.cnt   cif
);
    ckg_count_t cnt_r;
    logic       run_r;
    logic       done_r;

    assign cif.done = done_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r  <= 8'h00;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (cif.load) begin
            cnt_r  <= cif.start_val;
            run_r  <= 1'b1;
            done_r <= 1'b0;
        end else if (run_r && cif.tick) begin
            if (cnt_r == 8'h00) begin
                run_r  <= 1'b0;
                done_r <= 1'b1;
            end else begin
                cnt_r  <= cnt_r - 8'h01;
                done_r <= 1'b0;
            end
        end else begin
            done_r <= 1'b0;
        end
    end
endmodule // ckg_settle_counter

/* logic/ckg_clock_source_generator.sv */
// Clock generator control: slow clock selection, oscillator and PLL start-up control
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ckg_consts.svh"
// What this block does
// - Selector 0 picks RC, 1 picks crystal
// - Bypass takes external clock from crystal input
// - Slow control bits 0..3, kept on backup
// - Backup reset: RC on, crystal off, RC
// - Source change resynchronised within five slow cycles
// - Reset leaves main oscillator disabled
// - Disabling main oscillator clears stable flag
// - Enable write clears flag, starts slow/8 countdown
// - Countdown zero sets stable flag, maskable interrupt
// - Divider 1..255; zero forces PLL output low
// - Factor (mult+1)/div; zero multiplier disables PLL
// - PLL change with nonzero multiplier reloads settle count per slow clock
// - Master clock bit halves PLL output
// - USB PLL multiplies by fixed forty
// - USB enable reloads count at slow/8
module ckg_clock_source_generator
    import ckg_pkg::*;
(
    // Clock and resets
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        backup_resetn,
    // AXI4-Lite write channels
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Slow clock sources
    input  wire logic        rc_osc_clk,
    input  wire logic        watch_crystal_clk,
    input  wire logic        slow_crystal_in_pin,
    // Slow clock controls and result
    output logic             rc_osc_on,
    output logic             watch_crystal_on,
    output logic             watch_crystal_bypass,
    output logic             slow_source_pick,
    output logic             slow_clk,
    // Main oscillator
    output logic             main_osc_on,
    output logic             main_osc_bypass,
    // Main PLL
    output logic [7:0]       main_pll_prescale,
    output logic [10:0]      main_pll_feedback_factor,
    output logic             main_pll_run,
    output logic             main_pll_halve,
    // USB PLL
    output logic             usb_pll_on,
    output logic [7:0]       usb_pll_factor,
    output logic             hs_bias_on,
    // Status interrupt
    output logic             power_irq
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [`CKG_SLOW_W-1:0] slow_ctl_r;
    logic                   pick_r;
    logic                   mosc_on_r;
    logic                   mosc_byp_r;
    logic [7:0]             mosc_cnt_r;
    logic [7:0]             pll_div_r;
    logic [10:0]            pll_mul_r;
    logic [5:0]             pll_cnt_r;
    logic                   halve_r;
    logic                   usb_on_r;
    logic                   bias_r;
    logic [3:0]             usb_cnt_r;
    logic                   mosc_stable_r;
    logic                   pll_settled_r;
    logic                   usb_settled_r;
    logic [`CKG_SR_W-1:0]   imr_r;
    logic                   irq_r;
    logic                   pll_run_r;

    // ****************************************************************
    // Register read view
    // ****************************************************************
    function automatic logic [32:0] reg_view(input logic [31:0] addr);
        ckg_word_t d;
        logic      hit;
        d   = 32'h0000_0000;
        hit = 1'b1;
        case (addr)
            `CKG_ADDR_SLOW: d[`CKG_SLOW_W-1:0] = slow_ctl_r;
            `CKG_ADDR_MOSC: begin
                d[`CKG_MOSC_ON]  = mosc_on_r;
                d[`CKG_MOSC_BYP] = mosc_byp_r;
                d[`CKG_MOSC_CNT] = mosc_cnt_r;
            end
            `CKG_ADDR_PLL: begin
                d[`CKG_PLL_DIV] = pll_div_r;
                d[`CKG_PLL_CNT] = pll_cnt_r;
                d[`CKG_PLL_MUL] = pll_mul_r;
            end
            `CKG_ADDR_MCK: d[`CKG_MCK_HALVE] = halve_r;
            `CKG_ADDR_USB: begin
                d[`CKG_USB_ON]   = usb_on_r;
                d[`CKG_USB_CNT]  = usb_cnt_r;
                d[`CKG_USB_BIAS] = bias_r;
            end
            `CKG_ADDR_SR: begin
                d[`CKG_SR_MOSC] = mosc_stable_r;
                d[`CKG_SR_PLL]  = pll_settled_r;
                d[`CKG_SR_USB]  = usb_settled_r;
            end
            `CKG_ADDR_IMR: d[`CKG_SR_W-1:0] = imr_r;
            default: hit = 1'b0;
        endcase
        return {hit, d};
    endfunction

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic [31:0] aw_addr_r;
    ckg_word_t   w_data_r;
    logic [3:0]  w_strb_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    ckg_word_t   rdata_r;
    logic [32:0] wr_view;
    logic [32:0] rd_view;
    ckg_word_t   wr_mask;
    ckg_word_t   wv;
    logic        wr_fire;

    // Both halves held and no response pending
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign wr_view = reg_view(aw_addr_r);
    assign rd_view = reg_view(araddr);
    assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign wv      = (wr_view[31:0] & ~wr_mask) | (w_data_r & wr_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= CKG_RESP_OKAY;
            aw_addr_r <= 32'h0000_0000;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (awvalid && awready_r) begin
                aw_addr_r <= awaddr;
                awready_r <= 1'b0;
            end
            if (wvalid && wready_r) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_view[32] ? CKG_RESP_OKAY : CKG_RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= CKG_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_view[31:0];
            rresp_r   <= rd_view[32] ? CKG_RESP_OKAY : CKG_RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ****************************************************************
    // Write decode and side effects
    // ****************************************************************
    logic slow_wr;
    logic mosc_wr;
    logic pll_wr;
    logic usb_wr;
    logic pll_change;
    logic pll_load;
    logic usb_load;

    assign slow_wr    = wr_fire && (aw_addr_r == `CKG_ADDR_SLOW);
    assign mosc_wr    = wr_fire && (aw_addr_r == `CKG_ADDR_MOSC);
    assign pll_wr     = wr_fire && (aw_addr_r == `CKG_ADDR_PLL);
    assign usb_wr     = wr_fire && (aw_addr_r == `CKG_ADDR_USB);
    // Any change clears the flag; it restarts the count unless the new multiplier is zero
    assign pll_change = pll_wr && ((wv[`CKG_PLL_DIV] != pll_div_r) ||
                                   (wv[`CKG_PLL_MUL] != pll_mul_r) ||
                                   (wv[`CKG_PLL_CNT] != pll_cnt_r));
    assign pll_load   = pll_change && (wv[`CKG_PLL_MUL] != 11'h000);
    assign usb_load   = usb_wr && wv[`CKG_USB_ON] && !usb_on_r;

    // Backup domain: only backup reset loads its default (RC on)
    always_ff @(posedge aclk) begin
        if (!backup_resetn) begin
            slow_ctl_r <= `CKG_SLOW_RST;
        end else if (slow_wr) begin
            slow_ctl_r <= wv[`CKG_SLOW_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mosc_on_r  <= 1'b0;
            mosc_byp_r <= 1'b0;
            mosc_cnt_r <= 8'h00;
        end else if (mosc_wr) begin
            mosc_on_r  <= wv[`CKG_MOSC_ON];
            mosc_byp_r <= wv[`CKG_MOSC_BYP];
            mosc_cnt_r <= wv[`CKG_MOSC_CNT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_div_r <= 8'h00;
            pll_mul_r <= 11'h000;
            pll_cnt_r <= 6'h00;
        end else if (pll_wr) begin
            pll_div_r <= wv[`CKG_PLL_DIV];
            pll_mul_r <= wv[`CKG_PLL_MUL];
            pll_cnt_r <= wv[`CKG_PLL_CNT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halve_r <= 1'b0;
        end else if (wr_fire && (aw_addr_r == `CKG_ADDR_MCK)) begin
            halve_r <= wv[`CKG_MCK_HALVE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_on_r  <= 1'b0;
            bias_r    <= 1'b0;
            usb_cnt_r <= 4'h0;
        end else if (usb_wr) begin
            usb_on_r  <= wv[`CKG_USB_ON];
            bias_r    <= wv[`CKG_USB_BIAS];
            usb_cnt_r <= wv[`CKG_USB_CNT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imr_r <= 7'h00;
        end else if (wr_fire && (aw_addr_r == `CKG_ADDR_IMR)) begin
            imr_r <= wv[`CKG_SR_W-1:0] & `CKG_SR_MASK;
        end
    end

    // ****************************************************************
    // Slow clock source synchronisation and selection
    // ****************************************************************
    logic [2:0] src_meta_r;
    logic [2:0] src_sync_r;
    logic       rc_lvl;
    logic       xtal_lvl;
    logic       cur_lvl;
    logic       new_lvl;
    logic       switch_now;
    logic       slow_lvl;
    logic       slow_clk_r;
    logic       slow_tick;
    logic [2:0] div8_r;
    logic       tick8;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_meta_r <= 3'h0;
            src_sync_r <= 3'h0;
        end else begin
            src_meta_r <= {slow_crystal_in_pin, watch_crystal_clk, rc_osc_clk};
            src_sync_r <= src_meta_r;
        end
    end

    assign rc_lvl   = src_sync_r[`CKG_PIN_RC] && slow_ctl_r[`CKG_SLOW_RC];
    // Bypass takes the external pin
    assign xtal_lvl = slow_ctl_r[`CKG_SLOW_BYP] ? src_sync_r[`CKG_PIN_EXT] :
                      (src_sync_r[`CKG_PIN_OSC] && slow_ctl_r[`CKG_SLOW_XTAL]);
    assign cur_lvl  = pick_r ? xtal_lvl : rc_lvl;
    assign new_lvl  = slow_ctl_r[`CKG_SLOW_SEL] ? xtal_lvl : rc_lvl;
    // Hand over when the new source is high and slow_clk_r is low: slow_clk rises at the switch
    assign switch_now = (pick_r != slow_ctl_r[`CKG_SLOW_SEL]) && new_lvl && !slow_clk_r;
    assign slow_lvl   = switch_now ? new_lvl : cur_lvl;
    assign slow_tick  = slow_lvl && !slow_clk_r;
    assign tick8      = slow_tick && (div8_r == `CKG_DIV8_LAST);

    always_ff @(posedge aclk) begin
        if (!backup_resetn) begin
            pick_r <= 1'b0;
        end else if (switch_now) begin
            pick_r <= slow_ctl_r[`CKG_SLOW_SEL];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_clk_r <= 1'b0;
            div8_r     <= 3'h0;
        end else begin
            slow_clk_r <= slow_lvl;
            if (slow_tick) begin
                div8_r <= div8_r + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Settle counters
    // ****************************************************************
    ckg_cnt_if mosc_if ();
    ckg_cnt_if pll_if ();
    ckg_cnt_if usb_if ();

    assign mosc_if.load      = mosc_wr && wv[`CKG_MOSC_ON];
    assign mosc_if.start_val = wv[`CKG_MOSC_CNT];
    assign mosc_if.tick      = tick8;
    assign pll_if.load       = pll_load;
    assign pll_if.start_val  = {2'h0, wv[`CKG_PLL_CNT]};
    assign pll_if.tick       = slow_tick;
    assign usb_if.load       = usb_load;
    assign usb_if.start_val  = {4'h0, wv[`CKG_USB_CNT]};
    assign usb_if.tick       = tick8;

    ckg_settle_counter u_mosc_cnt (.aclk(aclk), .aresetn(aresetn), .cif(mosc_if));
    ckg_settle_counter u_pll_cnt  (.aclk(aclk), .aresetn(aresetn), .cif(pll_if));
    ckg_settle_counter u_usb_cnt  (.aclk(aclk), .aresetn(aresetn), .cif(usb_if));

    // ****************************************************************
    // Status flags and interrupt
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mosc_stable_r <= 1'b0;
        end else if (mosc_wr) begin
            mosc_stable_r <= 1'b0;
        end else if (mosc_if.done && mosc_on_r) begin
            mosc_stable_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_settled_r <= 1'b0;
        end else if (pll_change) begin
            pll_settled_r <= 1'b0;
        end else if (pll_if.done) begin
            pll_settled_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_settled_r <= 1'b0;
        end else if (usb_load || (usb_wr && !wv[`CKG_USB_ON])) begin
            usb_settled_r <= 1'b0;
        end else if (usb_if.done) begin
            usb_settled_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r     <= 1'b0;
            pll_run_r <= 1'b0;
        end else begin
            irq_r     <= (mosc_stable_r && imr_r[`CKG_SR_MOSC]) ||
                         (pll_settled_r && imr_r[`CKG_SR_PLL]) ||
                         (usb_settled_r && imr_r[`CKG_SR_USB]);
            // Zero divider or multiplier holds PLL low
            pll_run_r <= (pll_div_r != 8'h00) && (pll_mul_r != 11'h000);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign rc_osc_on = slow_ctl_r[`CKG_SLOW_RC];
    assign watch_crystal_on = slow_ctl_r[`CKG_SLOW_XTAL];
    assign watch_crystal_bypass = slow_ctl_r[`CKG_SLOW_BYP];
    assign slow_source_pick = pick_r;
    assign slow_clk = slow_clk_r;
    assign main_osc_on = mosc_on_r;
    assign main_osc_bypass = mosc_byp_r;
    assign main_pll_prescale = pll_div_r;
    assign main_pll_feedback_factor = pll_mul_r;
    assign main_pll_run = pll_run_r;
    assign main_pll_halve = halve_r;
    assign usb_pll_on = usb_on_r;
    assign usb_pll_factor = `CKG_USB_MULT;
    assign hs_bias_on = bias_r;
    assign power_irq = irq_r;
endmodule // ckg_clock_source_generator

/* bench/ckg_clock_source_generator_assertions.sv */
// Port checker for the clock generator control block
`timescale 1ns/1ps
module ckg_clock_source_generator_assertions
    import ckg_pkg::*;
(
    // Clock and resets
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        backup_resetn,
    // Write response
    input wire logic        bvalid,
    input wire logic        bready,
    // Slow clock
    input wire logic        rc_osc_clk,
    input wire logic        watch_crystal_clk,
    input wire logic        slow_crystal_in_pin,
    input wire logic        rc_osc_on,
    input wire logic        watch_crystal_on,
    input wire logic        watch_crystal_bypass,
    input wire logic        slow_source_pick,
    input wire logic        slow_clk,
    // Oscillator and PLLs
    input wire logic        main_osc_on,
    input wire logic [7:0]  main_pll_prescale,
    input wire logic [10:0] main_pll_feedback_factor,
    input wire logic        main_pll_run,
    input wire logic        main_pll_halve,
    input wire logic [7:0]  usb_pll_factor
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !backup_resetn);
    sequence s_wr; $rose(bvalid); endsequence
    sequence s_rc; (!slow_source_pick && $stable(rc_osc_clk))[*5]; endsequence
    sequence s_xt;
        (slow_source_pick && !watch_crystal_bypass && $stable(watch_crystal_clk))[*5];
    endsequence
    sequence s_ext;
        (slow_source_pick && watch_crystal_bypass && $stable(slow_crystal_in_pin))[*5];
    endsequence
    property p_rc_path; s_rc |-> slow_clk == rc_osc_clk; endproperty
    a_rc_path: assert property (p_rc_path)
        else $error("slow clock not from RC");
    property p_xt_path; s_xt |-> slow_clk == watch_crystal_clk; endproperty
    a_xt_path: assert property (p_xt_path)
        else $error("slow clock not from crystal");
    property p_ext_path; s_ext |-> slow_clk == slow_crystal_in_pin; endproperty
    a_ext_path: assert property (p_ext_path)
        else $error("slow clock not from pin");
    property p_backup_dflt;
        $rose(backup_resetn) |-> rc_osc_on && !watch_crystal_on && !watch_crystal_bypass
            && !slow_source_pick;
    endproperty
    a_backup_dflt: assert property (p_backup_dflt)
        else $error("bad backup default");
    property p_main_off;
        $rose(aresetn) |-> !main_osc_on && !main_pll_run && main_pll_prescale == 8'h00;
    endproperty
    a_main_off: assert property (p_main_off)
        else $error("clock active after reset");
    property p_pll_run;
        main_pll_run == ($past(main_pll_prescale) != 8'h00
            && $past(main_pll_feedback_factor) != 11'h000);
    endproperty
    a_pll_run: assert property (p_pll_run)
        else $error("PLL run wrong");
    property p_usb_mult; usb_pll_factor == 8'h28; endproperty
    a_usb_mult: assert property (p_usb_mult)
        else $error("USB factor wrong");
    property p_slow_wr;
        $changed({rc_osc_on, watch_crystal_on, watch_crystal_bypass}) && $past(backup_resetn)
            |-> s_wr;
    endproperty
    a_slow_wr: assert property (p_slow_wr)
        else $error("slow control changed alone");
    property p_osc_wr; $changed(main_osc_on) && $past(aresetn) |-> s_wr; endproperty
    a_osc_wr: assert property (p_osc_wr)
        else $error("osc enable changed alone");
    property p_halve_wr; $changed(main_pll_halve) && $past(aresetn) |-> s_wr; endproperty
    a_halve_wr: assert property (p_halve_wr)
        else $error("halve changed alone");
    property p_b_hold; bvalid && !bready |=> bvalid; endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("response dropped");
endmodule // ckg_clock_source_generator_assertions

bind ckg_clock_source_generator ckg_clock_source_generator_assertions u_chk (.*);

/* bench/ckg_clock_source_generator_tb.sv */
// Register-level testbench of the clock generator control block
`timescale 1ns/1ps
`include "ckg_consts.svh"
module ckg_clock_source_generator_tb;
    import ckg_pkg::*;
    logic aclk, aresetn, backup_resetn, awvalid, wvalid, bready, arvalid, rready;
    logic rc_osc_clk, watch_crystal_clk, slow_crystal_in_pin, awready, wready, bvalid;
    logic arready, rvalid, rc_osc_on, watch_crystal_on, watch_crystal_bypass;
    logic slow_source_pick, slow_clk, main_osc_on, main_osc_bypass, main_pll_run;
    logic main_pll_halve, usb_pll_on, hs_bias_on, power_irq;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    logic [5:0] cy;
    logic [7:0] main_pll_prescale, usb_pll_factor;
    logic [10:0] main_pll_feedback_factor;
    ckg_word_t awaddr, wdata, araddr, rdata, d;
    int fails, n_compared;

    ckg_clock_source_generator dut (.*);

    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    // Slow sources at different rates
    always @(posedge aclk) begin
        cy <= cy + 6'h01;
        rc_osc_clk <= cy[3];
        watch_crystal_clk <= cy[4];
        slow_crystal_in_pin <= cy[5];
    end

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input ckg_word_t seen, input ckg_word_t exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input ckg_word_t a, input ckg_word_t v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (bvalid !== 1'b1) begin fails++; conclude(); end
        bready <= 1'b0;
    endtask
    task rd(input ckg_word_t a, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (rvalid !== 1'b1) begin fails++; conclude(); end
        d = rdata; r = rresp; rready <= 1'b0;
    endtask
    task rc(input ckg_word_t a, input ckg_word_t e);
        logic [1:0] r;
        rd(a, r);
        chk(d, e, "register");
    endtask
    // Bounded status poll
    task poll(input int b);
        logic [1:0] r;
        for (int i = 0; i < 300; i++) begin
            rd(`CKG_ADDR_SR, r);
            if (d[b] === 1'b1) break;
        end
        chk(d[b], 1, "status bit");
    endtask

    initial begin
        logic [1:0] r;
        {aresetn, backup_resetn, awvalid, wvalid, bready, arvalid, rready, cy} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1; backup_resetn <= 1'b1;
        // ****************************************************************
        // Reset values and slow clock selection
        // ****************************************************************
        rc(`CKG_ADDR_SLOW, 32'h1);
        rc(`CKG_ADDR_MOSC, 32'h0);
        rc(`CKG_ADDR_PLL, 32'h0);
        wr(`CKG_ADDR_SLOW, 32'hfffffff3);
        rc(`CKG_ADDR_SLOW, 32'h3);
        wr(`CKG_ADDR_SLOW, 32'hb);
        repeat (160) @(posedge aclk);
        chk(slow_source_pick, 1, "pick");
        wr(`CKG_ADDR_SLOW, 32'hf);
        wr(`CKG_ADDR_SLOW, 32'hd);
        repeat (200) @(posedge aclk);
        chk(watch_crystal_bypass, 1, "bypass");
        wr(`CKG_ADDR_SLOW, 32'h5);
        repeat (80) @(posedge aclk);
        chk(slow_source_pick, 0, "pick");
        wr(`CKG_ADDR_SLOW, 32'h1);
        rd(32'h0ffff000, r);
        chk(r, 2, "resp");
        chk(d, 0, "data");
        $display("slow test done");
        // ****************************************************************
        // Main oscillator, PLL, USB PLL
        // ****************************************************************
        wr(`CKG_ADDR_IMR, 32'h43);
        wr(`CKG_ADDR_MOSC, 32'h201);
        chk(main_osc_on, 1, "osc on");
        rc(`CKG_ADDR_SR, 32'h0);
        poll(0);
        chk(power_irq, 1, "irq");
        wr(`CKG_ADDR_MOSC, 32'h2);
        chk(main_osc_bypass, 1, "osc bypass");
        rc(`CKG_ADDR_SR, 32'h0);
        chk(power_irq, 0, "irq");
        wr(`CKG_ADDR_PLL, 32'h10301);
        poll(1);
        chk(main_pll_run, 1, "pll run");
        wr(`CKG_ADDR_PLL, 32'h301);
        rc(`CKG_ADDR_SR, 32'h0);
        wr(`CKG_ADDR_USB, 32'h110000);
        chk(usb_pll_on, 1, "usb on");
        poll(6);
        wr(`CKG_ADDR_USB, 32'h1110000);
        chk(hs_bias_on, 1, "bias");
        chk(usb_pll_factor, 32'h28, "usb factor");
        wr(`CKG_ADDR_MCK, 32'h1000);
        chk(main_pll_halve, 1, "halve");
        $display("PLL test done");
        conclude();
    end
endmodule // ckg_clock_source_generator_tb
